/* core/temp_trim_transient_options_regs.sv */
// trim, transient options and identity command registers for two channels
// assumes commands arrive already decoded from the management interface
`timescale 1ns/10ps
`default_nettype none
module temp_trim_transient_options_regs #(
	parameter int          NUM_CH     = 2,
	parameter logic [11:0] PART_ID    = 12'h5A1, // arbitrary value
	parameter logic [3:0]  PART_REV   = trim_opts_pkg::FIRST_REVISION,
	parameter int          AVG_SHIFT  = 2,
	parameter int          GAIN_SHIFT = 12
)(
	// clock and reset
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	// command port
	input  wire logic                       cmd_wr,
	input  wire logic                       cmd_rd,
	input  wire logic [7:0]                 cmd_code,
	input  wire logic                       cmd_page,
	input  wire logic [15:0]                cmd_wdata,
	output logic      [15:0]                cmd_rdata,
	output logic                            cmd_rvalid,
	output logic                            cmd_unsupported,
	output logic                            cmd_invalid_data,
	// saved user settings restore
	input  wire logic                       restore_valid,
	input  wire logic                       restore_page,
	input  wire logic [15:0]                restore_trim,
	// temperature measurement
	input  wire logic [NUM_CH-1:0]          temp_valid,
	input  wire logic [NUM_CH-1:0][15:0]    temp_raw,
	input  wire logic [NUM_CH-1:0][15:0]    current_sense_gain,
	input  wire logic [15:0]                gain_tc,
	input  wire logic [15:0]                temp_ref,
	output logic      [NUM_CH-1:0][15:0]    temp_report,
	output logic      [NUM_CH-1:0]          temp_report_valid,
	output logic      [NUM_CH-1:0][15:0]    gain_compensated,
	// transient comparator events
	input  wire logic [NUM_CH-1:0]          comp_rise,
	input  wire logic [NUM_CH-1:0]          comp_drop,
	output logic      [NUM_CH-1:0][7:0]     comp_threshold_mv,
	output logic      [NUM_CH-1:0][7:0]     valley_threshold_mv,
	output logic      [NUM_CH-1:0]          averaging_select,
	output logic      [NUM_CH-1:0]          pulse_inject,
	output logic      [NUM_CH-1:0]          high_side_off,
	output logic      [NUM_CH-1:0]          low_side_off
);
	import trim_opts_pkg::*;

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic trim_in_range(input logic [10:0] m);
		logic signed [10:0] s;
		s = m;
		trim_in_range = (s >= $signed(TRIM_MANT_MIN)) &&
		                (s <= $signed(TRIM_MANT_MAX));
	endfunction

	function automatic logic [7:0] thr_mv(input logic [1:0] sel);
		case (sel)
			2'h0:    thr_mv = THR_MV_0;
			2'h1:    thr_mv = THR_MV_1;
			2'h2:    thr_mv = THR_MV_2;
			default: thr_mv = THR_MV_3;
		endcase
	endfunction

	function automatic logic [15:0] trim_word(input logic [10:0] m);
		trim_word = {TRIM_EXPONENT, m};
	endfunction

	// --------------------------------------------------------------
	// register state
	// --------------------------------------------------------------
	logic [NUM_CH-1:0][10:0] trim_mant_r;
	logic [NUM_CH-1:0][15:0] opts_r;
	logic                    restore_done_r;
	logic                    restore_go;
	logic                    wr_trim;
	logic                    wr_opts;
	logic                    wr_trim_bad;
	logic                    restore_bad;
	logic [15:0]             identity;

	assign identity    = {PART_ID, PART_REV};
	assign wr_trim     = cmd_wr && (cmd_code == CMD_TEMP_TRIM);
	assign wr_opts     = cmd_wr && (cmd_code == CMD_OPTIONS);
	assign wr_trim_bad = wr_trim && !trim_in_range(cmd_wdata[10:0]);
	assign restore_go  = restore_valid && !restore_done_r;
	assign restore_bad = restore_go && !trim_in_range(restore_trim[10:0]);

	// --------------------------------------------------------------
	// saved settings load once after reset release
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			restore_done_r <= 1'b0;
		else if (restore_valid)
			restore_done_r <= 1'b1;
	end

	// --------------------------------------------------------------
	// temperature trim registers
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int c = 0; c < NUM_CH; c++)
				trim_mant_r[c] <= TRIM_MANT_RESET;
		end
		else
		begin
			if (restore_go && !restore_bad)
				trim_mant_r[restore_page] <= restore_trim[10:0];
			if (wr_trim && !wr_trim_bad)
				trim_mant_r[cmd_page] <= cmd_wdata[10:0];
		end
	end

	// --------------------------------------------------------------
	// transient options registers
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int c = 0; c < NUM_CH; c++)
				opts_r[c] <= OPT_RESET;
		end
		else if (wr_opts)
		begin
			opts_r[cmd_page] <= cmd_wdata & OPT_WR_MASK;
		end
	end

	// --------------------------------------------------------------
	// read path and command status
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_rdata  <= 16'h0000;
			cmd_rvalid <= 1'b0;
		end
		else
		begin
			cmd_rvalid <= cmd_rd;
			if (cmd_rd)
			begin
				case (cmd_code)
					CMD_TEMP_TRIM:
						cmd_rdata <= trim_word(trim_mant_r[cmd_page]);
					CMD_OPTIONS:
						cmd_rdata <= opts_r[cmd_page];
					CMD_IDENTITY:
						cmd_rdata <= identity;
					default:
						cmd_rdata <= 16'h0000;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_unsupported  <= 1'b0;
			cmd_invalid_data <= 1'b0;
		end
		else
		begin
			cmd_unsupported  <= (cmd_rd || cmd_wr) &&
			                    (cmd_code != CMD_TEMP_TRIM) &&
			                    (cmd_code != CMD_OPTIONS) &&
			                    (cmd_code != CMD_IDENTITY);
			cmd_invalid_data <= wr_trim_bad;
		end
	end

	// --------------------------------------------------------------
	// per channel temperature path and transient controls
	// --------------------------------------------------------------
	for (genvar c = 0; c < NUM_CH; c++)
	begin : g_ch
		logic signed [15:0] rep;

		temp_trim_channel #(
			.AVG_SHIFT  (AVG_SHIFT),
			.GAIN_SHIFT (GAIN_SHIFT)
		) u_trim (
			.sys_clk      (sys_clk),
			.rst_n        (rst_n),
			.sample_valid (temp_valid[c]),
			.temp_raw     (temp_raw[c]),
			.trim_mant    (trim_mant_r[c]),
			.gain_base    (current_sense_gain[c]),
			.gain_tc      (gain_tc),
			.temp_ref     (temp_ref),
			.temp_report  (rep),
			.gain_comp    (gain_compensated[c]),
			.report_valid (temp_report_valid[c])
		);
		assign temp_report[c] = rep;

		always_ff @(posedge sys_clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				comp_threshold_mv[c]   <= THR_MV_0;
				valley_threshold_mv[c] <= VALLEY_MV_LOW;
				averaging_select[c]    <= 1'b0;
			end
			else
			begin
				comp_threshold_mv[c] <=
					thr_mv(opts_r[c][OPT_THR_LSB+1:OPT_THR_LSB]);
				valley_threshold_mv[c] <= opts_r[c][OPT_VALLEY_RAISE] ?
				                          VALLEY_MV_HIGH : VALLEY_MV_LOW;
				averaging_select[c] <= opts_r[c][OPT_AVG_SEL];
			end
		end

		always_ff @(posedge sys_clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				pulse_inject[c]  <= 1'b0;
				high_side_off[c] <= 1'b0;
				low_side_off[c]  <= 1'b0;
			end
			else
			begin
				pulse_inject[c]  <= opts_r[c][OPT_PULSE_EN] & comp_rise[c];
				high_side_off[c] <= opts_r[c][OPT_VALLEY_EN] & comp_drop[c];
				low_side_off[c]  <= opts_r[c][OPT_VALLEY_EN] & comp_drop[c];
			end
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_trim_exp_fixed: assert property (
		cmd_rd && cmd_code == CMD_TEMP_TRIM |=>
			cmd_rdata[15:11] == TRIM_EXPONENT)
		else $error("trim exponent not fixed");

	a_trim_bad_kept: assert property (
		wr_trim_bad && !restore_go |=>
			trim_mant_r[$past(cmd_page)] == $past(trim_mant_r[cmd_page])
			&& cmd_invalid_data)
		else $error("out of range trim accepted");

	a_opts_mask: assert property (
		wr_opts |=> (opts_r[$past(cmd_page)] & ~OPT_WR_MASK) == 16'h0000)
		else $error("read-only option bits written");

	a_opts_store: assert property (
		wr_opts ##1 !cmd_wr ##1 (cmd_rd && cmd_code == CMD_OPTIONS &&
		             cmd_page == $past(cmd_page, 2)) |=>
			cmd_rdata == ($past(cmd_wdata, 3) & OPT_WR_MASK))
		else $error("options write not read back");

	a_thr_decode: assert property (
		opts_r[0][1:0] == 2'h2 && $stable(opts_r[0]) |=>
			comp_threshold_mv[0] == THR_MV_2)
		else $error("threshold select decode wrong");

	a_valley_raise: assert property (
		opts_r[0][OPT_VALLEY_RAISE] |=>
			valley_threshold_mv[0] == VALLEY_MV_HIGH)
		else $error("valley threshold not raised");

	a_cutoff_both: assert property (
		opts_r[0][OPT_VALLEY_EN] && comp_drop[0] |=>
			high_side_off[0] && low_side_off[0])
		else $error("valley cutoff missed a drive");

	a_pulse_gate: assert property (
		!opts_r[0][OPT_PULSE_EN] |=> !pulse_inject[0])
		else $error("pulse injected while disabled");

	a_avg_follow: assert property (
		##1 averaging_select[0] == $past(opts_r[0][OPT_AVG_SEL]))
		else $error("averaging select not following");

	a_identity_rd: assert property (
		cmd_rd && cmd_code == CMD_IDENTITY |=>
			cmd_rvalid && cmd_rdata == {PART_ID, PART_REV})
		else $error("identity word wrong");

	a_restore_load: assert property (
		restore_go && !restore_bad && !wr_trim |=>
			trim_mant_r[$past(restore_page)] == $past(restore_trim[10:0]))
		else $error("saved trim not restored");
endmodule
`default_nettype wire

/* core/trim_opts_pkg.sv */
// constants for the temperature trim, transient options and identity words
// assumes one system clock and a command-level management port in front
package trim_opts_pkg;

	// --------------------------------------------------------------
	// command codes
	// --------------------------------------------------------------
	localparam logic [7:0]  CMD_TEMP_TRIM    = 8'hEE;
	localparam logic [7:0]  CMD_OPTIONS      = 8'hF0;
	localparam logic [7:0]  CMD_IDENTITY     = 8'hFC;

	// --------------------------------------------------------------
	// temperature trim layout
	// --------------------------------------------------------------
	localparam int          TRIM_MANT_W      = 11;
	localparam int          TRIM_EXP_LSB     = 11;
	localparam logic [4:0]  TRIM_EXPONENT    = 5'h1F;
	localparam logic [15:0] TRIM_RESET       = 16'hF800;
	localparam logic [10:0] TRIM_MANT_RESET  = 11'h000;
	localparam logic [10:0] TRIM_MANT_MIN    = 11'h7F8;
	localparam logic [10:0] TRIM_MANT_MAX    = 11'h006;

	// --------------------------------------------------------------
	// transient options layout
	// --------------------------------------------------------------
	localparam logic [15:0] OPT_RESET        = 16'h0000;
	localparam logic [15:0] OPT_WR_MASK      = 16'h003F;
	localparam int          OPT_VALLEY_RAISE = 5;
	localparam int          OPT_VALLEY_EN    = 4;
	localparam int          OPT_AVG_SEL      = 3;
	localparam int          OPT_PULSE_EN     = 2;
	localparam int          OPT_THR_LSB      = 0;

	// --------------------------------------------------------------
	// thresholds in mV
	// --------------------------------------------------------------
	localparam logic [7:0]  VALLEY_MV_LOW    = 8'h32;
	localparam logic [7:0]  VALLEY_MV_HIGH   = 8'h64;
	localparam logic [7:0]  THR_MV_0         = 8'h23;
	localparam logic [7:0]  THR_MV_1         = 8'h3C;
	localparam logic [7:0]  THR_MV_2         = 8'h55;
	localparam logic [7:0]  THR_MV_3         = 8'h6E;

	// --------------------------------------------------------------
	// identity layout
	// --------------------------------------------------------------
	localparam int          ID_REV_W         = 4;
	localparam int          ID_CODE_W        = 12;
	localparam logic [3:0]  FIRST_REVISION   = 4'h0;

endpackage

/* core/temp_trim_channel.sv */
// per-channel temperature trim, averaging and current gain compensation
// assumes one converted temperature sample per sample_valid pulse
`timescale 1ns/10ps
`default_nettype none
module temp_trim_channel #(
	parameter int AVG_SHIFT  = 2,
	parameter int GAIN_SHIFT = 12
)(
	// clock and reset
	input  wire logic                                   sys_clk,
	input  wire logic                                   rst_n,
	// temperature sample, 0.5 degree units
	input  wire logic                                   sample_valid,
	input  wire logic signed [15:0]                     temp_raw,
	input  wire logic        [trim_opts_pkg::TRIM_MANT_W-1:0] trim_mant,
	// gain compensation inputs
	input  wire logic        [15:0]                     gain_base,
	input  wire logic signed [15:0]                     gain_tc,
	input  wire logic signed [15:0]                     temp_ref,
	// results
	output logic signed      [15:0]                     temp_report,
	output logic             [15:0]                     gain_comp,
	output logic                                        report_valid
);
	import trim_opts_pkg::*;

	logic signed [15:0] trim_ext;
	logic signed [16:0] sum_wide;
	logic signed [15:0] adj;
	logic signed [16:0] diff;
	logic signed [15:0] avg_nxt;
	logic signed [16:0] delta;
	logic signed [32:0] prod;
	logic               first_r;

	// --------------------------------------------------------------
	// trim and average
	// --------------------------------------------------------------
	// sign extension of trim
	assign trim_ext = {{(16-TRIM_MANT_W){trim_mant[TRIM_MANT_W-1]}},
	                   trim_mant};
	assign sum_wide = 17'(temp_raw) + 17'(trim_ext);
	assign adj      = (sum_wide > 17'sh07FFF) ? 16'sh7FFF :
	                  (sum_wide < -17'sh08000) ? -16'sh8000 :
	                  sum_wide[15:0];
	assign diff     = 17'(adj) - 17'(temp_report);
	assign avg_nxt  = 16'(17'(temp_report) + (diff >>> AVG_SHIFT));

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			temp_report <= 16'sh0000;
			first_r     <= 1'b1;
		end
		else if (sample_valid)
		begin
			temp_report <= first_r ? adj : avg_nxt;
			first_r     <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			report_valid <= 1'b0;
		else
			report_valid <= sample_valid;
	end

	// --------------------------------------------------------------
	// gain compensation
	// --------------------------------------------------------------
	assign delta = 17'(temp_report) - 17'(temp_ref);
	assign prod  = 33'(delta) * 33'(gain_tc);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			gain_comp <= 16'h0000;
		else
			gain_comp <= 16'(gain_base + 16'(prod >>> GAIN_SHIFT));
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_report_valid: assert property (
		sample_valid |=> report_valid)
		else $error("report valid missing after sample");
	a_first_trim: assert property (
		first_r && sample_valid |=> temp_report == $past(adj))
		else $error("first report is not raw plus trim");
endmodule
`default_nettype wire

/* sim/cmd_host_model.sv */
// management host model driving the command port of the register block
// assumes inputs are driven at the falling edge of sys_clk
`timescale 1ns/10ps
`default_nettype none
module cmd_host_model (
	// clock
	input  wire logic        sys_clk,
	// command port
	output logic             cmd_wr,
	output logic             cmd_rd,
	output logic      [7:0]  cmd_code,
	output logic             cmd_page,
	output logic      [15:0] cmd_wdata,
	// answers
	input  wire logic [15:0] cmd_rdata,
	input  wire logic        cmd_rvalid,
	input  wire logic        cmd_unsupported,
	input  wire logic        cmd_invalid_data
);
	initial
	begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_code = 8'h00;
		cmd_page = 1'b0;
		cmd_wdata = 16'h0000;
	end

	// write one word; st = {unsupported, invalid data}
	task automatic wr(input logic [7:0] c, input logic p,
		input logic [15:0] d, output logic [1:0] st);
		@(negedge sys_clk);
		cmd_wr = 1'b1;
		cmd_code = c;
		cmd_page = p;
		cmd_wdata = d;
		@(negedge sys_clk);
		cmd_wr = 1'b0;
		// released data no longer shows the last word
		cmd_wdata = ~d;
		st = {cmd_unsupported, cmd_invalid_data};
	endtask

	// read one word with its valid and unsupported flags
	task automatic rd(input logic [7:0] c, input logic p,
		output logic [15:0] d, output logic rv, output logic un);
		@(negedge sys_clk);
		cmd_rd = 1'b1;
		cmd_code = c;
		cmd_page = p;
		@(negedge sys_clk);
		cmd_rd = 1'b0;
		d = cmd_rdata;
		rv = cmd_rvalid;
		un = cmd_unsupported;
	endtask
endmodule
`default_nettype wire

/* sim/tb_temp_trim_transient_options_regs.sv */
// testbench of the trim, transient options and identity registers
// assumes the host model in cmd_host_model.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) chk(16'(g), 16'(e))
module tb_temp_trim_transient_options_regs;
	import trim_opts_pkg::*;
	localparam logic [11:0] ID_T = 12'h2B4; // arbitrary value
	logic             sys_clk;
	logic             rst_n;
	logic             cmd_wr, cmd_rd, cmd_page;
	logic [7:0]       cmd_code;
	logic [15:0]      cmd_wdata, cmd_rdata;
	logic             cmd_rvalid, cmd_unsupported, cmd_invalid_data;
	logic             restore_valid, restore_page;
	logic [15:0]      restore_trim, gain_tc, temp_ref, rd_d;
	logic [1:0]       temp_valid, temp_report_valid, comp_rise, comp_drop;
	logic [1:0][15:0] temp_raw, current_sense_gain;
	logic [1:0][15:0] temp_report, gain_compensated;
	logic [1:0][7:0]  comp_threshold_mv, valley_threshold_mv;
	logic [1:0]       averaging_select, pulse_inject;
	logic [1:0]       high_side_off, low_side_off, st;
	logic             rv, un;
	int               n_mismatch = 0;
	int               checks = 0;
	int               cyc = 0;
	logic [15:0]      tw [5] = '{16'hFFFF, 16'h0006, 16'h0007,
		16'h07F8, 16'h07F7};
	logic             tbad [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
	logic [15:0]      tr [5] = '{16'hFFFF, 16'hF806, 16'hF806,
		16'hFFF8, 16'hFFF8};
	logic [7:0]       thr_t [4] = '{THR_MV_0, THR_MV_1, THR_MV_2,
		THR_MV_3};

	temp_trim_transient_options_regs #(.PART_ID(ID_T)) uut (
		.sys_clk, .rst_n, .cmd_wr, .cmd_rd, .cmd_code, .cmd_page,
		.cmd_wdata, .cmd_rdata, .cmd_rvalid, .cmd_unsupported,
		.cmd_invalid_data, .restore_valid, .restore_page,
		.restore_trim, .temp_valid, .temp_raw, .current_sense_gain,
		.gain_tc, .temp_ref, .temp_report, .temp_report_valid,
		.gain_compensated, .comp_rise, .comp_drop,
		.comp_threshold_mv, .valley_threshold_mv,
		.averaging_select, .pulse_inject, .high_side_off,
		.low_side_off
	);

	cmd_host_model host (
		.sys_clk, .cmd_wr, .cmd_rd, .cmd_code, .cmd_page,
		.cmd_wdata, .cmd_rdata, .cmd_rvalid, .cmd_unsupported,
		.cmd_invalid_data
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// compare and close
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic end_sim;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		restore_valid = 1'b0;
		restore_page = 1'b1;
		restore_trim = 16'h0005;
		temp_valid = 2'b00;
		temp_raw = '0;
		current_sense_gain = {16'h0200, 16'h0100};
		gain_tc = 16'h1000;
		temp_ref = 16'h0000;
		comp_rise = 2'b00;
		comp_drop = 2'b00;
		repeat (16) @(negedge sys_clk);
		rst_n = 1'b1;
		restore_valid = 1'b1;
		repeat (3) @(negedge sys_clk);
		restore_valid = 1'b0;
		`CHK(comp_threshold_mv[0], THR_MV_0);
		`CHK(valley_threshold_mv[0], VALLEY_MV_LOW);
		host.rd(CMD_TEMP_TRIM, 1'b0, rd_d, rv, un);
		`CHK(rd_d, TRIM_RESET);
		`CHK({un, rv}, 2'b01);
		host.rd(CMD_TEMP_TRIM, 1'b1, rd_d, rv, un);
		`CHK(rd_d, 16'hF805);
		host.rd(CMD_OPTIONS, 1'b0, rd_d, rv, un);
		`CHK(rd_d, OPT_RESET);
		host.rd(CMD_IDENTITY, 1'b0, rd_d, rv, un);
		`CHK(rd_d, {ID_T, FIRST_REVISION});
		// trim writes at and beyond the range limits
		for (int i = 0; i < 5; i++)
		begin
			host.wr(CMD_TEMP_TRIM, 1'b0, tw[i], st);
			`CHK(st, {1'b0, tbad[i]});
			host.rd(CMD_TEMP_TRIM, 1'b0, rd_d, rv, un);
			`CHK(rd_d, tr[i]);
		end
		host.wr(CMD_OPTIONS, 1'b1, 16'hFFFF, st);
		host.rd(CMD_OPTIONS, 1'b1, rd_d, rv, un);
		`CHK(rd_d, 16'h003F);
		host.rd(CMD_OPTIONS, 1'b0, rd_d, rv, un);
		`CHK(rd_d, 16'h0000);
		`CHK(comp_threshold_mv[1], THR_MV_3);
		`CHK(valley_threshold_mv[1], VALLEY_MV_HIGH);
		`CHK(averaging_select, 2'b10);
		comp_rise = 2'b11;
		comp_drop = 2'b11;
		@(negedge sys_clk);
		`CHK(pulse_inject, 2'b10);
		`CHK(high_side_off, 2'b10);
		`CHK(low_side_off, 2'b10);
		comp_rise = 2'b00;
		comp_drop = 2'b00;
		@(negedge sys_clk);
		`CHK(pulse_inject, 2'b00);
		for (int k = 0; k < 4; k++)
		begin
			host.wr(CMD_OPTIONS, 1'b0, 16'(k) | 16'h0038, st);
			repeat (2) @(negedge sys_clk);
			`CHK(comp_threshold_mv[0], thr_t[k]);
		end
		// channel 0 now has valley raise, cutoff and averaging on
		`CHK(valley_threshold_mv[0], VALLEY_MV_HIGH);
		`CHK(averaging_select, 2'b11);
		comp_rise = 2'b01;
		comp_drop = 2'b01;
		@(negedge sys_clk);
		`CHK(pulse_inject, 2'b00);
		`CHK(high_side_off, 2'b01);
		`CHK(low_side_off, 2'b01);
		comp_rise = 2'b00;
		comp_drop = 2'b00;
		host.wr(CMD_IDENTITY, 1'b0, 16'hFFFF, st);
		host.rd(CMD_IDENTITY, 1'b0, rd_d, rv, un);
		`CHK(rd_d, {ID_T, FIRST_REVISION});
		host.rd(8'hEF, 1'b0, rd_d, rv, un);
		`CHK(un, 1'b1);
		`CHK(rd_d, 16'h0000);
		// trims now -8 on channel 0 and +5 on channel 1
		temp_raw = {16'hFFEC, 16'd100};
		temp_valid = 2'b11;
		@(negedge sys_clk);
		temp_valid = 2'b00;
		`CHK(temp_report_valid, 2'b11);
		`CHK(temp_report[0], 16'd92);
		`CHK(temp_report[1], 16'hFFF1);
		repeat (2) @(negedge sys_clk);
		`CHK(gain_compensated[0], 16'h015C);
		`CHK(gain_compensated[1], 16'h01F1);
		temp_raw[0] = 16'd112;
		temp_valid = 2'b01;
		@(negedge sys_clk);
		temp_valid = 2'b00;
		`CHK(temp_report[0], 16'd95);
		restore_trim = 16'h0003;
		restore_valid = 1'b1;
		repeat (3) @(negedge sys_clk);
		restore_valid = 1'b0;
		host.rd(CMD_TEMP_TRIM, 1'b1, rd_d, rv, un);
		`CHK(rd_d, 16'hF805);
		end_sim();
	end
endmodule
`default_nettype wire
